// ### hlt_pkg.sv
package hlt_pkg;

   // =====================================================
   // register bus
   // =====================================================
   localparam int          ADDR_W         = 8;
   localparam int          DATA_W         = 8;
   localparam logic [7:0]  OFS_CTRL       = 8'h00;
   localparam logic [7:0]  OFS_PERIOD     = 8'h04;
   localparam logic [7:0]  OFS_COUNT      = 8'h08;
   localparam logic [7:0]  OFS_STATUS     = 8'h0C;

   // =====================================================
   // field layout
   // =====================================================
   localparam int          CTRL_ON_BIT    = 7;
   localparam int          CTRL_MODE_LSB  = 0;
   localparam int          MODE_W         = 5;
   localparam int          ST_RUN_BIT     = 0;
   localparam int          ST_START_BIT   = 1;
   localparam int          ST_LEVEL_BIT   = 2;
   localparam int          ST_MATCH_BIT   = 3;
   localparam int          ST_RSVD_BIT    = 4;

   // =====================================================
   // reset values
   // =====================================================
   localparam logic [7:0]  COUNT_RST      = 8'h00;
   localparam logic [7:0]  PERIOD_RST     = 8'hFF;
   localparam logic [4:0]  MODE_RST       = 5'h00;

   // =====================================================
   // timing demanded of the trigger source, in timer clocks
   // =====================================================
   localparam int          EDGE_SPACING_CYCLES = 6;
   localparam int          LEVEL_HOLD_CYCLES   = 3;

   // =====================================================
   // mode encoding
   // =====================================================
   typedef enum logic [1:0] {
      FAM_PERIOD   = 2'b00,
      FAM_ONESHOT  = 2'b01,
      FAM_MONO     = 2'b10,
      FAM_RESERVED = 2'b11
   } mode_family_t;

   localparam logic [2:0]  VAR_SOFT       = 3'h0;
   localparam logic [2:0]  VAR_RISE       = 3'h1;
   localparam logic [2:0]  VAR_FALL       = 3'h2;
   localparam logic [2:0]  VAR_ANY        = 3'h3;
   localparam logic [2:0]  VAR_RISE_RST   = 3'h4;
   localparam logic [2:0]  VAR_FALL_RST   = 3'h5;
   localparam logic [2:0]  VAR_LOW_RST    = 3'h6;
   localparam logic [2:0]  VAR_HIGH_RST   = 3'h7;

endpackage : hlt_pkg

// ### trig_if.sv
`timescale 1ns/1ns
`default_nettype none
interface trig_if;
   logic level;
   logic rise;
   logic fall;
   modport src (output level, output rise, output fall);
   modport snk (input level, input rise, input fall);
endinterface : trig_if
`default_nettype wire

// ### trigger_edge_detect.sv
`timescale 1ns/1ns
`default_nettype none
module trigger_edge_detect
   import hlt_pkg::*;
(
   // clock and reset
   input  wire logic clk_sys,
   input  wire logic rst,
   // external side
   input  wire logic external_trigger_signal,
   input  wire logic debug_mode,
   // qualified trigger
   trig_if.src       trig
);

   logic level_reg;
   logic rise_reg;
   logic fall_reg;

   // =====================================================
   // level sample, frozen in debug
   // =====================================================
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         level_reg <= 1'b0;
      end else if (!debug_mode) begin
         level_reg <= external_trigger_signal;
      end
   end

   // =====================================================
   // edge pulses, aligned with the level change
   // =====================================================
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rise_reg <= 1'b0;
         fall_reg <= 1'b0;
      end else begin
         rise_reg <= !debug_mode && external_trigger_signal && !level_reg;
         fall_reg <= !debug_mode && !external_trigger_signal && level_reg;
      end
   end

   assign trig.level = level_reg;
   assign trig.rise  = rise_reg;
   assign trig.fall  = fall_reg;

   AST_DEBUG_NO_EDGE: assert property (@(posedge clk_sys) disable iff (rst)
      debug_mode |=> !rise_reg && !fall_reg && $stable(level_reg))
      else $error("edge seen while debug freezes trigger");

endmodule : trigger_edge_detect
`default_nettype wire

// ### hlt_timer.sv
// Our own choices: strobed register access and the address map.
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - five-bit mode, upper two bits pick family, 11 reserved, lower three variant
// - external trigger and reset inputs are ignored in debug mode
// - software gate counts each clock while enabled, holds while disabled
// - free-running period match returns count to zero next clock, keeps counting
// - hardware gate 001 counts while signal high, 010 while low
// - free-running 011/100/101 clear count on either, rising, falling edge
// - free-running 110 holds reset while low, 111 while high
// - one-shot software start runs when enabled, no external signal needed
// - one-shot 001/010/011 start on rising, falling, any edge after enable
// - one-shot 100/101 start on edge, later same edges clear count
// - one-shot 110 rise start, low reset; 111 fall start, high reset
// - monostable edge start; match stops count at zero, enable kept
// - level start 110 runs high, resets low; 111 inverted
// - after enable cleared, edge modes need a fresh edge to restart
// - one-shot and level-start match clears enable, stops count at zero
// - reset clears count and sets period to all ones
module hlt_timer
   import hlt_pkg::*;
(
   // clock and reset
   input  wire logic              clk_sys,
   input  wire logic              rst,
   // register port
   input  wire logic [ADDR_W-1:0] reg_addr,
   input  wire logic [DATA_W-1:0] reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic      [DATA_W-1:0] reg_rdata,
   // external trigger
   input  wire logic              external_trigger_signal,
   input  wire logic              debug_mode,
   // timer state
   output logic      [7:0]        count_value,
   output logic                   period_match
);

   // =====================================================
   // state
   // =====================================================
   logic [7:0]        count_value_reg;
   logic [7:0]        period_value_reg;
   logic [4:0]        mode_reg;
   logic              on_reg;
   logic              started_reg;
   logic              match_seen_reg;
   logic [DATA_W-1:0] rdata_reg;
   logic              match_reg;

   mode_family_t      family;
   logic [2:0]        variant;
   logic              run;
   logic              hold_rst;
   logic              edge_clr;
   logic              start_evt;
   logic              edge_start;
   logic              stop_at_match;
   logic              clear_on;
   logic              match;
   logic              wr_ctrl;
   logic              wr_period;
   logic              wr_count;
   logic              wr_status;

   trig_if trig ();

   trigger_edge_detect u_edge (
      .clk_sys                 (clk_sys),
      .rst                     (rst),
      .external_trigger_signal (external_trigger_signal),
      .debug_mode              (debug_mode),
      .trig                    (trig)
   );

   function automatic logic edge_of(input logic [1:0] sel, input logic r, input logic f);
      logic hit;
      hit = 1'b0;
      unique case (sel)
         2'b01:   hit = r;
         2'b10:   hit = f;
         2'b11:   hit = r | f;
         2'b00:   hit = 1'b0;
      endcase
      return hit;
   endfunction : edge_of

   function automatic logic is_addr(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
      return a == ofs;
   endfunction : is_addr

   // =====================================================
   // register decode
   // =====================================================
   assign wr_ctrl   = reg_wr && is_addr(reg_addr, OFS_CTRL);
   assign wr_period = reg_wr && is_addr(reg_addr, OFS_PERIOD);
   assign wr_count  = reg_wr && is_addr(reg_addr, OFS_COUNT);
   assign wr_status = reg_wr && is_addr(reg_addr, OFS_STATUS);

   assign family  = mode_family_t'(mode_reg[4:3]);
   assign variant = mode_reg[2:0];
   assign match   = count_value_reg == period_value_reg;

   // =====================================================
   // mode decode
   // =====================================================
   always_comb begin
      run           = 1'b0;
      hold_rst      = 1'b0;
      edge_clr      = 1'b0;
      start_evt     = 1'b0;
      edge_start    = 1'b0;
      stop_at_match = 1'b0;
      clear_on      = 1'b0;
      unique case (family)
         FAM_PERIOD: begin
            unique case (variant)
               VAR_SOFT:     run = on_reg;
               VAR_RISE:     run = on_reg && trig.level;
               VAR_FALL:     run = on_reg && !trig.level;
               VAR_ANY, VAR_RISE_RST, VAR_FALL_RST: begin
                  run      = on_reg;
                  edge_clr = on_reg && edge_of(variant == VAR_ANY ? 2'b11 :
                             variant == VAR_RISE_RST ? 2'b01 : 2'b10, trig.rise, trig.fall);
               end
               VAR_LOW_RST: begin
                  hold_rst = on_reg && !trig.level;
                  run      = on_reg && trig.level;
               end
               VAR_HIGH_RST: begin
                  hold_rst = on_reg && trig.level;
                  run      = on_reg && !trig.level;
               end
            endcase
         end
         FAM_ONESHOT: begin
            clear_on = 1'b1;
            unique case (variant)
               VAR_SOFT: run = on_reg;
               VAR_RISE, VAR_FALL, VAR_ANY: begin
                  edge_start = 1'b1;
                  start_evt  = on_reg && edge_of(variant[1:0], trig.rise, trig.fall);
                  run        = on_reg && started_reg;
               end
               VAR_RISE_RST, VAR_FALL_RST: begin
                  edge_start = 1'b1;
                  start_evt  = on_reg && edge_of(variant == VAR_RISE_RST ? 2'b01 : 2'b10,
                                                 trig.rise, trig.fall);
                  edge_clr   = start_evt && started_reg;
                  run        = on_reg && started_reg;
               end
               VAR_LOW_RST: begin
                  edge_start = 1'b1;
                  start_evt  = on_reg && trig.rise;
                  hold_rst   = on_reg && !trig.level;
                  run        = on_reg && started_reg && trig.level;
               end
               VAR_HIGH_RST: begin
                  edge_start = 1'b1;
                  start_evt  = on_reg && trig.fall;
                  hold_rst   = on_reg && trig.level;
                  run        = on_reg && started_reg && !trig.level;
               end
            endcase
         end
         FAM_MONO: begin
            unique case (variant)
               VAR_RISE, VAR_FALL, VAR_ANY: begin
                  edge_start    = 1'b1;
                  stop_at_match = 1'b1;
                  start_evt     = on_reg && edge_of(variant[1:0], trig.rise, trig.fall);
                  run           = on_reg && started_reg;
               end
               VAR_LOW_RST: begin
                  clear_on = 1'b1;
                  hold_rst = on_reg && !trig.level;
                  run      = on_reg && trig.level;
               end
               VAR_HIGH_RST: begin
                  clear_on = 1'b1;
                  hold_rst = on_reg && trig.level;
                  run      = on_reg && !trig.level;
               end
               VAR_SOFT, VAR_RISE_RST, VAR_FALL_RST: run = 1'b0;
            endcase
         end
         FAM_RESERVED: run = 1'b0;
      endcase
   end

   // =====================================================
   // counter
   // =====================================================
   // hardware reset and edge clear outrank a software count write
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         count_value_reg <= COUNT_RST;
      end else if (hold_rst || edge_clr) begin
         count_value_reg <= COUNT_RST;
      end else if (wr_count) begin
         count_value_reg <= reg_wdata;
      end else if (run && match) begin
         count_value_reg <= COUNT_RST;
      end else if (run) begin
         count_value_reg <= count_value_reg + 8'h01;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         period_value_reg <= PERIOD_RST;
      end else if (wr_period) begin
         period_value_reg <= reg_wdata;
      end
   end

   // =====================================================
   // control: enable and mode
   // =====================================================
   // a software write in the match cycle wins so a re-arm is not lost
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         on_reg   <= 1'b0;
         mode_reg <= MODE_RST;
      end else if (wr_ctrl) begin
         on_reg   <= reg_wdata[CTRL_ON_BIT];
         mode_reg <= reg_wdata[CTRL_MODE_LSB +: MODE_W];
      end else if (run && match && clear_on && !hold_rst && !edge_clr) begin
         on_reg <= 1'b0;
      end
   end

   // =====================================================
   // start latch for edge-started modes
   // =====================================================
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         started_reg <= 1'b0;
      end else if (!on_reg || !edge_start) begin
         started_reg <= 1'b0;
      end else if (start_evt) begin
         started_reg <= 1'b1;
      end else if (run && match && !hold_rst && !edge_clr) begin
         started_reg <= 1'b0;
      end
   end

   // =====================================================
   // match flag and sticky status
   // =====================================================
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         match_reg <= 1'b0;
      end else begin
         match_reg <= run && match && !hold_rst && !edge_clr;
      end
   end

   // set wins over a write-one-to-clear in the same cycle
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         match_seen_reg <= 1'b0;
      end else if (run && match && !hold_rst && !edge_clr) begin
         match_seen_reg <= 1'b1;
      end else if (wr_status && reg_wdata[ST_MATCH_BIT]) begin
         match_seen_reg <= 1'b0;
      end
   end

   // =====================================================
   // read data, one cycle after the strobe
   // =====================================================
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rdata_reg <= 8'h00;
      end else if (reg_rd) begin
         rdata_reg <= 8'h00;
         if (is_addr(reg_addr, OFS_CTRL)) begin
            rdata_reg[CTRL_ON_BIT]                  <= on_reg;
            rdata_reg[CTRL_MODE_LSB +: MODE_W]      <= mode_reg;
         end else if (is_addr(reg_addr, OFS_PERIOD)) begin
            rdata_reg <= period_value_reg;
         end else if (is_addr(reg_addr, OFS_COUNT)) begin
            rdata_reg <= count_value_reg;
         end else if (is_addr(reg_addr, OFS_STATUS)) begin
            rdata_reg[ST_RUN_BIT]   <= run;
            rdata_reg[ST_START_BIT] <= started_reg;
            rdata_reg[ST_LEVEL_BIT] <= trig.level;
            rdata_reg[ST_MATCH_BIT] <= match_seen_reg;
            rdata_reg[ST_RSVD_BIT]  <= (family == FAM_RESERVED) ||
                                       (family == FAM_MONO && (variant == VAR_SOFT ||
                                        variant == VAR_RISE_RST || variant == VAR_FALL_RST));
         end
      end else begin
         rdata_reg <= 8'h00;
      end
   end

   assign reg_rdata    = rdata_reg;
   assign count_value  = count_value_reg;
   assign period_match = match_reg;

   // =====================================================
   // checks
   // =====================================================
   AST_RESERVED_STILL: assert property (@(posedge clk_sys) disable iff (rst)
      (mode_reg[4:3] == 2'b11) && !wr_count |=> $stable(count_value_reg))
      else $error("counter moved in reserved mode");

   AST_SWGATE_COUNT: assert property (@(posedge clk_sys) disable iff (rst)
      (mode_reg == 5'h00) && on_reg && !match && !wr_count
      |=> count_value_reg == $past(count_value_reg) + 8'h01)
      else $error("software gate did not advance");

   AST_SWGATE_HOLD: assert property (@(posedge clk_sys) disable iff (rst)
      (mode_reg == 5'h00) && !on_reg && !wr_count |=> $stable(count_value_reg))
      else $error("software gate advanced while disabled");

   AST_PERIOD_WRAP: assert property (@(posedge clk_sys) disable iff (rst)
      (mode_reg[4:3] == 2'b00) && run && match && !wr_count && !wr_ctrl
      |=> count_value_reg == 8'h00 ##1 (count_value_reg == 8'h01 || !$past(run) || $past(match) ||
          $past(wr_count) || $past(hold_rst) || $past(edge_clr)))
      else $error("free-running wrap wrong");

   AST_GATE_HIGH: assert property (@(posedge clk_sys) disable iff (rst)
      (mode_reg == 5'h01) && !trig.level && !wr_count |=> $stable(count_value_reg))
      else $error("active-high gate counted while low");

   AST_EDGE_CLEAR: assert property (@(posedge clk_sys) disable iff (rst)
      (mode_reg == 5'h03) && on_reg && (trig.rise || trig.fall) |=> count_value_reg == 8'h00)
      else $error("edge did not clear count");

   AST_LEVEL_RESET: assert property (@(posedge clk_sys) disable iff (rst)
      (mode_reg == 5'h06) && on_reg && !trig.level |=> count_value_reg == 8'h00)
      else $error("low level did not hold reset");

   AST_ONESHOT_STOP: assert property (@(posedge clk_sys) disable iff (rst)
      (mode_reg[4:3] == 2'b01) && run && match && !hold_rst && !edge_clr && !wr_ctrl && !wr_count
      |=> !on_reg && count_value_reg == 8'h00)
      else $error("one-shot did not stop at match");

   AST_MONO_KEEP_ON: assert property (@(posedge clk_sys) disable iff (rst)
      stop_at_match && run && match && !wr_ctrl && !wr_count
      |=> on_reg && !started_reg && count_value_reg == 8'h00)
      else $error("monostable match handling wrong");

   AST_FRESH_EDGE: assert property (@(posedge clk_sys) disable iff (rst)
      !on_reg |=> !started_reg)
      else $error("start latch survived disable");

   AST_RESET_VALUES: assert property (@(posedge clk_sys)
      rst |=> count_value_reg == 8'h00 && period_value_reg == 8'hFF && !on_reg)
      else $error("reset values wrong");

endmodule : hlt_timer
`default_nettype wire

// ### trig_src.sv
`timescale 1ns/1ns
`default_nettype none
// =====================================================
// external trigger source
// =====================================================
module trig_src (
   // clock
   input  wire logic clk_sys,
   // trigger line
   output logic      external_trigger_signal
);
   initial external_trigger_signal = 1'b0;

   // one change per call, then a quiet spell that covers both spacing limits
   task automatic drive(input logic v);
      @(posedge clk_sys) external_trigger_signal <= v;
      repeat (6) @(posedge clk_sys);
   endtask : drive
endmodule : trig_src
`default_nettype wire

// ### testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
   import hlt_pkg::*;
   // =====================================================
   // stimulus and wiring
   // =====================================================
   logic              clk_sys;
   logic              rst;
   logic [ADDR_W-1:0] reg_addr;
   logic [DATA_W-1:0] reg_wdata;
   logic              reg_wr;
   logic              reg_rd;
   logic              debug_mode;
   logic [DATA_W-1:0] reg_rdata;
   logic [7:0]        count_value;
   logic              period_match;
   logic              external_trigger_signal;
   int                fail_count = 0;
   int                n_checks   = 0;
   int                cyc        = 0;

   always #20 clk_sys = ~clk_sys;

   hlt_timer dut_u (
      .clk_sys                 (clk_sys),
      .rst                     (rst),
      .reg_addr                (reg_addr),
      .reg_wdata               (reg_wdata),
      .reg_wr                  (reg_wr),
      .reg_rd                  (reg_rd),
      .reg_rdata               (reg_rdata),
      .external_trigger_signal (external_trigger_signal),
      .debug_mode              (debug_mode),
      .count_value             (count_value),
      .period_match            (period_match)
   );
   trig_src src_u (
      .clk_sys                 (clk_sys),
      .external_trigger_signal (external_trigger_signal)
   );

   // =====================================================
   // helpers
   // =====================================================
   task automatic give_verdict;
      $display("checks=%0d mismatches=%0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : give_verdict

   // a full run takes well under a thousand cycles
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         fail_count++;
         give_verdict();
      end
   end

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
         fail_count++;
      end
   endtask : check

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys) begin reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d; end
      @(posedge clk_sys) reg_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_sys) begin reg_rd <= 1'b1; reg_addr <= a; end
      @(posedge clk_sys) reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd

   // each cycle must advance by one, wrapping to zero after the period value
   task automatic run_seq(input int n, input logic [7:0] per);
      logic [7:0] prev;
      @(posedge clk_sys) #1 prev = count_value;
      repeat (n) begin
         @(posedge clk_sys) #1 check(count_value, (prev == per) ? 8'h00 : prev + 8'h01);
         check({7'h00, period_match}, {7'h00, prev == per});
         prev = count_value;
      end
   endtask : run_seq

   task automatic hold_seq(input int n);
      logic [7:0] prev;
      @(posedge clk_sys) #1 prev = count_value;
      repeat (n) @(posedge clk_sys) #1 check(count_value, prev);
   endtask : hold_seq

   // =====================================================
   // scenarios
   // =====================================================
   task automatic t_reset;
      logic [7:0] d;
      rd(OFS_PERIOD, d); check(d, PERIOD_RST);
      rd(OFS_COUNT, d); check(d, COUNT_RST);
      wr(8'h20, 8'h55); rd(8'h20, d); check(d, 8'h00);
      $display("test reset done");
   endtask : t_reset

   task automatic t_gates;
      wr(OFS_PERIOD, 8'h03); wr(OFS_CTRL, 8'h80); repeat (2) @(posedge clk_sys);
      run_seq(10, 8'h03);
      wr(OFS_CTRL, 8'h00); repeat (2) @(posedge clk_sys); hold_seq(4);
      wr(OFS_PERIOD, 8'hFF); wr(OFS_COUNT, 8'h00); wr(OFS_CTRL, 8'h81);
      repeat (2) @(posedge clk_sys); hold_seq(4);
      src_u.drive(1'b1); run_seq(4, 8'hFF);
      wr(OFS_CTRL, 8'h82); repeat (2) @(posedge clk_sys); hold_seq(4);
      src_u.drive(1'b0); run_seq(4, 8'hFF);
      $display("test gates done");
   endtask : t_gates

   task automatic t_resets;
      logic [7:0] m [3] = '{8'h84, 8'h85, 8'h83};
      for (int i = 0; i < 3; i++) begin
         wr(OFS_CTRL, m[i]); wr(OFS_COUNT, 8'h40); repeat (2) @(posedge clk_sys);
         src_u.drive(~external_trigger_signal);
         #1 check({7'h00, count_value < 8'h08}, 8'h01);
      end
      wr(OFS_CTRL, 8'h87); @(posedge clk_sys) #1 check(count_value, 8'h00); hold_seq(3);
      src_u.drive(1'b0); run_seq(3, 8'hFF);
      wr(OFS_CTRL, 8'h86); repeat (3) @(posedge clk_sys); #1 check(count_value, 8'h00);
      $display("test hardware reset done");
   endtask : t_resets

   task automatic t_oneshot;
      logic [7:0] d;
      wr(OFS_PERIOD, 8'h02); wr(OFS_COUNT, 8'h00); wr(OFS_CTRL, 8'h89); hold_seq(4);
      src_u.drive(1'b1);
      rd(OFS_CTRL, d); check(d, 8'h09);
      #1 check(count_value, 8'h00);
      rd(OFS_STATUS, d); check(d & 8'h08, 8'h08);
      wr(OFS_STATUS, 8'h08); wr(OFS_PERIOD, 8'hFF); wr(OFS_CTRL, 8'h89);
      src_u.drive(1'b0); src_u.drive(1'b1);
      wr(OFS_CTRL, 8'h09); wr(OFS_CTRL, 8'h89); repeat (2) @(posedge clk_sys); hold_seq(3);
      wr(OFS_CTRL, 8'h88); repeat (2) @(posedge clk_sys); run_seq(3, 8'hFF);
      $display("test one-shot done");
   endtask : t_oneshot

   task automatic t_mono;
      logic [7:0] d;
      wr(OFS_CTRL, 8'h00); wr(OFS_PERIOD, 8'h02); wr(OFS_COUNT, 8'h00); wr(OFS_STATUS, 8'h08);
      src_u.drive(1'b0); wr(OFS_CTRL, 8'h91); src_u.drive(1'b1);
      rd(OFS_CTRL, d); check(d, 8'h91);
      #1 check(count_value, 8'h00);
      rd(OFS_STATUS, d); check(d & 8'h08, 8'h08);
      $display("test monostable done");
   endtask : t_mono

   task automatic t_debug_rsvd;
      logic [7:0] d;
      src_u.drive(1'b0); wr(OFS_CTRL, 8'h09); wr(OFS_COUNT, 8'h00);
      @(posedge clk_sys) debug_mode <= 1'b1;
      wr(OFS_CTRL, 8'h89); src_u.drive(1'b1); hold_seq(4);
      check(count_value, 8'h00);
      @(posedge clk_sys) debug_mode <= 1'b0;
      wr(OFS_CTRL, 8'h98); wr(OFS_COUNT, 8'h05);
      src_u.drive(1'b0); hold_seq(4);
      rd(OFS_STATUS, d); check(d & 8'h10, 8'h10);
      $display("test debug and reserved done");
   endtask : t_debug_rsvd

   // later rising edges restart the one-shot; level start stops at match
   task automatic t_hw_start;
      logic [7:0] d;
      wr(OFS_PERIOD, 8'hFF); wr(OFS_CTRL, 8'h8C); wr(OFS_COUNT, 8'h00);
      src_u.drive(1'b1); #1 check(count_value, 8'h04);
      src_u.drive(1'b0); src_u.drive(1'b1); #1 check(count_value, 8'h04);
      wr(OFS_PERIOD, 8'h03); wr(OFS_CTRL, 8'h96);
      src_u.drive(1'b0); #1 check(count_value, 8'h00);
      src_u.drive(1'b1); rd(OFS_CTRL, d); check(d, 8'h16);
      check(count_value, 8'h00);
      $display("test hardware start done");
   endtask : t_hw_start

   initial begin
      clk_sys    = 1'b0;
      rst        = 1'b1;
      reg_addr   = 8'h00;
      reg_wdata  = 8'h00;
      reg_wr     = 1'b0;
      reg_rd     = 1'b0;
      debug_mode = 1'b0;
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      t_reset();
      t_gates();
      t_resets();
      t_oneshot();
      t_mono();
      t_debug_rsvd();
      t_hw_start();
      give_verdict();
   end
endmodule : testbench
`default_nettype wire
